// ---- atc_trig_ctrl.sv ----
// module: main trigger controller with register port and record sequencing
//
// The register addresses and the plain strobed port were left to the implementer.
`default_nettype none
module atc_trig_ctrl import atc_pkg::*; #(
  parameter int unsigned REC_LEN = 1024,
  parameter int unsigned AW = $clog2(REC_LEN),
  parameter int unsigned SMP_DIV = 1,
  parameter int unsigned HOLD_MAX = HOLD_MAX_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // comparator outputs, asynchronous
  input wire logic [3:0] ch_hi,
  input wire logic [3:0] ch_lo,
  input wire logic line_hi,
  input wire logic aux_hi,
  // front end control
  output logic [2:0] cpl_sel,
  output logic [2:0] trig_src,
  // record store
  output logic cap_we,
  output logic [AW-1:0] cap_addr,
  output logic acq_done,
  // status lights
  output logic st_arm,
  output logic st_ready,
  output logic st_trigd
);
  typedef struct packed {
    atc_state_t st;
    logic [9:0] s1;
    logic [9:0] s2;
    logic [9:0] s3;
    logic [9:0] sv;
    logic [31:0] ctrl;
    logic [31:0] hold;
    logic [31:0] tdiv;
    logic [6:0] pct;
    logic [15:0] plim;
    logic [31:0] shw;
    logic pend;
    logic forced;
    logic [15:0] dcnt;
    logic [AW:0] cnt;
    logic [AW-1:0] waddr;
    logic [AW-1:0] tzero;
    logic [31:0] hcnt;
    logic [35:0] ato;
    logic we;
    logic [AW-1:0] addr;
    logic done;
    logic arm;
    logic ready;
    logic trigd;
    logic [2:0] cpl;
    logic [31:0] rdata;
  } atc_st_t;
  atc_st_t r_q;
  atc_st_t r_d;

  atc_qual_if qi ();

  atc_qual u_qual (
    .ref_clk(ref_clk),
    .rst(rst),
    .q(qi.qual)
  );

  logic run, auto_m, dhold, tick, fwr, trig;
  logic [1:0] ttype;
  logic [2:0] cpl_req;
  logic [6:0] pc;
  logic [AW:0] pre_n, post_n;
  logic [35:0] hreq, atmo;
  logic [31:0] hload;

  // synchronised sources; hi uses ch_hi, lo uses ch_lo, line_hi and aux_hi feed both
  assign qi.hi = {2'h0, r_q.sv[5:0]};
  assign qi.lo = {2'h0, r_q.sv[5:4], r_q.sv[9:6]};
  assign qi.src = r_q.ctrl[B_SRC +: 3];
  assign qi.ttype = r_q.ctrl[B_TYPE +: 2];
  assign qi.slope = r_q.ctrl[B_SLOPE];
  assign qi.pcls = r_q.ctrl[B_PCLS +: 3];
  assign qi.lcls = r_q.ctrl[B_LCLS +: 2];
  assign qi.lop = r_q.ctrl[B_LOP +: 2];
  assign qi.plim = r_q.plim;
  assign qi.setup = r_q.shw[15:0];
  assign qi.hold = r_q.shw[31:16];

  always_comb begin
    r_d = r_q;
    // a change counts only once the second and third stages agree
    r_d.s1 = {ch_lo, aux_hi, line_hi, ch_hi};
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.sv = (~(r_q.s2 ^ r_q.s3) & r_q.s3) | ((r_q.s2 ^ r_q.s3) & r_q.sv);

    run = r_q.ctrl[B_RUN];
    auto_m = r_q.ctrl[B_AUTO];
    dhold = r_q.ctrl[B_DHOLD];
    ttype = r_q.ctrl[B_TYPE +: 2];
    cpl_req = r_q.ctrl[B_CPL +: 3];
    fwr = reg_wr && (reg_addr == A_FORCE);

    pc = (r_q.pct > 7'h64) ? 7'h64 : r_q.pct;
    pre_n = (AW + 1)'((32'(pc) * REC_LEN) / 100);
    post_n = (AW + 1)'(REC_LEN) - pre_n;

    hreq = dhold ? 36'(r_q.tdiv) * 36'(DFLT_DIVS) : 36'(r_q.hold);
    if (hreq < 36'(HOLD_MIN_CYC)) begin
      hload = 32'(HOLD_MIN_CYC);
    end else if (hreq > 36'(HOLD_MAX)) begin
      hload = 32'(HOLD_MAX);
    end else begin
      hload = hreq[31:0];
    end
    // timeout scales with the timebase
    atmo = 36'(r_q.tdiv) * 36'(AUTO_DIVS);

    tick = (r_q.dcnt == 16'(SMP_DIV - 1));
    r_d.dcnt = tick ? 16'h0 : r_q.dcnt + 16'h1;

    if (reg_wr) begin
      case (reg_addr)
        A_CTRL: r_d.ctrl = reg_wdata;
        A_HOLD: r_d.hold = reg_wdata;
        A_TDIV: r_d.tdiv = reg_wdata;
        A_PRE: r_d.pct = reg_wdata[6:0];
        A_PLIM: r_d.plim = reg_wdata[15:0];
        A_SHW: r_d.shw = reg_wdata;
        default: ;
      endcase
    end

    // auto timer runs only in auto mode
    if (auto_m && r_q.ato != 36'h0 && r_q.st != ST_IDLE) begin
      r_d.ato = r_q.ato - 36'h1;
    end

    trig = 1'b0;
    r_d.we = 1'b0;
    r_d.done = 1'b0;
    case (r_q.st)
      ST_IDLE: begin
        if (run) begin
          r_d.st = ST_ARM;
          r_d.cnt = '0;
          r_d.ato = atmo;
        end
      end
      ST_ARM: begin
        if (r_q.cnt >= pre_n) begin
          r_d.st = ST_READY;
        end else if (tick) begin
          r_d.we = 1'b1;
          r_d.cnt = r_q.cnt + (AW + 1)'(1);
        end
      end
      ST_READY: begin
        r_d.we = tick;
        // without an event, pending force or auto expiry nothing completes
        trig = qi.ev || r_q.pend || (auto_m && r_q.ato == 36'h0);
        if (trig) begin
          r_d.st = ST_TRIGD;
          r_d.tzero = r_q.waddr;
          r_d.cnt = '0;
          r_d.forced = !qi.ev;
          r_d.pend = 1'b0;
          if (auto_m) begin
            r_d.ato = atmo;
          end
        end
      end
      ST_TRIGD: begin
        // qualifier events are not looked at here
        if (r_q.cnt >= post_n) begin
          r_d.st = ST_HOLD;
          r_d.hcnt = hload;
          r_d.done = 1'b1;
        end else if (tick) begin
          r_d.we = 1'b1;
          r_d.cnt = r_q.cnt + (AW + 1)'(1);
        end
      end
      ST_HOLD: begin
        if (r_q.hcnt == 32'h0) begin
          r_d.st = ST_ARM;
          r_d.cnt = '0;
        end else begin
          r_d.hcnt = r_q.hcnt - 32'h1;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase

    if (r_d.we) begin
      r_d.addr = r_q.waddr;
      r_d.waddr = (r_q.waddr == AW'(REC_LEN - 1)) ? '0 : r_q.waddr + AW'(1);
    end

    if (!run) begin
      r_d.st = ST_IDLE;
      r_d.we = 1'b0;
      r_d.done = 1'b0;
      r_d.pend = 1'b0;
    end
    // a new request wins over the one being consumed
    if (fwr && run) begin
      r_d.pend = 1'b1;
    end

    r_d.arm = (r_d.st == ST_ARM);
    r_d.ready = (r_d.st == ST_READY);
    r_d.trigd = (r_d.st == ST_TRIGD);
    r_d.cpl = (ttype == TT_EDGE && cpl_req <= CP_NR) ? cpl_req : CP_DC;

    r_d.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: r_d.rdata = r_q.ctrl;
        A_HOLD: r_d.rdata = r_q.hold;
        A_TDIV: r_d.rdata = r_q.tdiv;
        A_PRE: r_d.rdata = {25'h0, r_q.pct};
        A_PLIM: r_d.rdata = {16'h0, r_q.plim};
        A_SHW: r_d.rdata = r_q.shw;
        A_STAT: r_d.rdata = {26'h0, r_q.forced, r_q.pend,
          r_q.st == ST_HOLD, r_q.trigd, r_q.ready, r_q.arm};
        A_TZERO: r_d.rdata = 32'(r_q.tzero);
        default: r_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_q <= '{st: ST_IDLE, ctrl: CTRL_RST, hold: HOLD_RST, tdiv: TDIV_RST,
        pct: PRE_RST, plim: PLIM_RST, shw: SHW_RST, cpl: CP_DC,
        default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign cpl_sel = r_q.cpl;
  assign trig_src = r_q.ctrl[B_SRC +: 3];
  assign cap_we = r_q.we;
  assign cap_addr = r_q.addr;
  assign acq_done = r_q.done;
  assign st_arm = r_q.arm;
  assign st_ready = r_q.ready;
  assign st_trigd = r_q.trigd;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_trig_entry;
    (r_q.st == ST_READY) ##1 (r_q.st == ST_TRIGD);
  endsequence
  sequence s_hold_entry;
    (r_q.st == ST_TRIGD) ##1 (r_q.st == ST_HOLD);
  endsequence

  property p_tzero;
    s_trig_entry |-> r_q.tzero == $past(r_q.waddr);
  endproperty
  a_tzero: assert property (p_tzero) else $error("bad time zero");

  property p_lock;
    (r_q.st == ST_TRIGD) |=> $stable(r_q.tzero);
  endproperty
  a_lock: assert property (p_lock) else $error("retriggered");

  property p_hold_range;
    s_hold_entry |-> (r_q.hcnt >= HOLD_MIN_CYC && r_q.hcnt <= HOLD_MAX);
  endproperty
  a_hold_range: assert property (p_hold_range) else $error("holdoff");

  property p_hold_dflt;
    s_hold_entry ##0 ($past(dhold) && $past(hreq) >= 36'(HOLD_MIN_CYC) &&
      $past(hreq) <= 36'(HOLD_MAX)) |->
      36'(r_q.hcnt) == 36'($past(r_q.tdiv)) * 36'(DFLT_DIVS);
  endproperty
  a_hold_dflt: assert property (p_hold_dflt) else $error("dflt hold");

  property p_hold_block;
    (r_q.st == ST_HOLD && r_q.hcnt != 32'h0) |=>
      (r_q.st == ST_HOLD || r_q.st == ST_IDLE);
  endproperty
  a_hold_block: assert property (p_hold_block) else $error("early arm");

  property p_dark;
    (r_q.st == ST_IDLE) |-> !(st_arm || st_ready || st_trigd);
  endproperty
  a_dark: assert property (p_dark) else $error("lights on");

  property p_force_idle;
    (fwr && !run) |=> !r_q.pend;
  endproperty
  a_force_idle: assert property (p_force_idle) else $error("force kept");

  property p_force_acq;
    (r_q.st == ST_READY && r_q.pend && run) |=>
      (r_q.st == ST_TRIGD && r_q.tzero == $past(r_q.waddr));
  endproperty
  a_force_acq: assert property (p_force_acq) else $error("no force");

  property p_auto;
    (r_q.st == ST_READY && auto_m && r_q.ato == 36'h0 && run) |=>
      (r_q.st == ST_TRIGD);
  endproperty
  a_auto: assert property (p_auto) else $error("no auto trigger");

  property p_normal;
    (!auto_m && r_q.st != ST_IDLE && r_q.st != ST_READY) |=>
      $stable(r_q.ato);
  endproperty
  a_normal: assert property (p_normal) else $error("timer ran");

  property p_cpl;
    (ttype != TT_EDGE) |=> (cpl_sel == CP_DC);
  endproperty
  a_cpl: assert property (p_cpl) else $error("coupling");
endmodule : atc_trig_ctrl
`default_nettype wire

// ---- atc_pkg.sv ----
// package: constants and types of the acquisition trigger controller
`default_nettype none
package atc_pkg;
  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned HOLD_MIN_NS = 250;
  localparam int unsigned HOLD_MIN_CYC = (HOLD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_MAX_S = 12;
  localparam int unsigned HOLD_MAX_CYC = HOLD_MAX_S * CLK_HZ;
  localparam int unsigned DFLT_DIVS = 5;
  localparam int unsigned AUTO_DIVS = 10;
  // register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FORCE = 8'h04;
  localparam logic [7:0] A_HOLD = 8'h08;
  localparam logic [7:0] A_TDIV = 8'h0c;
  localparam logic [7:0] A_PRE = 8'h10;
  localparam logic [7:0] A_PLIM = 8'h14;
  localparam logic [7:0] A_SHW = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_TZERO = 8'h20;
  // control word fields
  localparam int B_RUN = 0;
  localparam int B_AUTO = 1;
  localparam int B_DHOLD = 2;
  localparam int B_SLOPE = 3;
  localparam int B_SRC = 4;
  localparam int B_TYPE = 7;
  localparam int B_CPL = 9;
  localparam int B_PCLS = 12;
  localparam int B_LCLS = 15;
  localparam int B_LOP = 17;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HOLD_RST = 32'(HOLD_MIN_CYC);
  localparam logic [31:0] TDIV_RST = 32'h0000_0064;
  localparam logic [6:0] PRE_RST = 7'h32;
  localparam logic [15:0] PLIM_RST = 16'h0010;
  localparam logic [31:0] SHW_RST = 32'h0004_0004;
  // codes
  localparam logic [1:0] TT_EDGE = 2'h0;
  localparam logic [1:0] TT_PULSE = 2'h1;
  localparam logic [1:0] TT_LOGIC = 2'h2;
  localparam logic [2:0] PC_GLITCH = 3'h0;
  localparam logic [2:0] PC_RUNT = 3'h1;
  localparam logic [2:0] PC_WIDTH = 3'h2;
  localparam logic [2:0] PC_SLEW = 3'h3;
  localparam logic [2:0] PC_TMO = 3'h4;
  localparam logic [1:0] LC_PAT = 2'h0;
  localparam logic [1:0] LC_STATE = 2'h1;
  localparam logic [1:0] LC_SH = 2'h2;
  localparam logic [2:0] CP_DC = 3'h0;
  localparam logic [2:0] CP_NR = 3'h4;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARM = 5'b00010,
    ST_READY = 5'b00100,
    ST_TRIGD = 5'b01000,
    ST_HOLD = 5'b10000
  } atc_state_t;
endpackage : atc_pkg
`default_nettype wire

// ---- atc_qual_if.sv ----
// interface: settings to the qualifier and its trigger event back
`default_nettype none
interface atc_qual_if;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [2:0] src;
  logic [1:0] ttype;
  logic slope;
  logic [2:0] pcls;
  logic [1:0] lcls;
  logic [1:0] lop;
  logic [15:0] plim;
  logic [15:0] setup;
  logic [15:0] hold;
  logic ev;
  modport ctl (output hi, lo, src, ttype, slope, pcls, lcls, lop, plim,
    setup, hold, input ev);
  modport qual (input hi, lo, src, ttype, slope, pcls, lcls, lop, plim,
    setup, hold, output ev);
endinterface : atc_qual_if
`default_nettype wire

// ---- atc_qual.sv ----
// module: edge, pulse and logic qualification of the trigger sources
`default_nettype none
module atc_qual import atc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // settings in, event out
  atc_qual_if.qual q
);
  typedef struct packed {
    logic s;
    logic l;
    logic f;
    logic ck;
    logic d;
    logic runt;
    logic [15:0] cnt;
    logic [15:0] lcnt;
    logic [15:0] dcnt;
    logic [15:0] hcnt;
    logic ev;
  } atc_qst_t;
  atc_qst_t r_q;
  atc_qst_t r_d;
  logic s, l, act, pact, la, pla, f, ck_e, ev;
  logic [3:0] v;

  always_comb begin
    r_d = r_q;
    s = q.hi[q.src];
    l = q.lo[q.src];
    act = s ^ q.slope;
    pact = r_q.s ^ q.slope;
    la = l ^ q.slope;
    pla = r_q.l ^ q.slope;
    // duplicating a member keeps and/or neutral for the 3-input state case
    v = (q.lcls == LC_PAT) ? q.hi[3:0] : {q.hi[2], q.hi[2:0]};
    f = (q.lop[0] ? |v : &v) ^ q.lop[1];
    r_d.ck = q.hi[3] ^ q.slope;
    ck_e = r_d.ck & ~r_q.ck;
    r_d.s = s;
    r_d.l = l;
    r_d.f = f;
    r_d.d = q.hi[0];
    r_d.cnt = (s != r_q.s) ? 16'h0 : r_q.cnt + {15'h0, r_q.cnt != 16'hffff};
    r_d.lcnt = (la & ~pla) ? 16'h0 : r_q.lcnt + {15'h0, r_q.lcnt != 16'hffff};
    r_d.dcnt = (r_d.d != r_q.d) ? 16'h0 :
      r_q.dcnt + {15'h0, r_q.dcnt != 16'hffff};
    r_d.hcnt = ck_e ? 16'h0 : r_q.hcnt + {15'h0, r_q.hcnt != 16'hffff};
    if (la & ~pla) begin
      r_d.runt = 1'b1;
    end
    if ((act & ~pact) | (~la & pla)) begin
      r_d.runt = 1'b0;
    end
    ev = 1'b0;
    case (q.ttype)
      TT_EDGE: ev = act & ~pact;
      TT_PULSE: begin
        case (q.pcls)
          PC_GLITCH: ev = ~act & pact & (r_q.cnt < q.plim);
          PC_RUNT: ev = ~la & pla & r_q.runt;
          PC_WIDTH: ev = ~act & pact & (r_q.cnt >= q.plim);
          PC_SLEW: ev = act & ~pact & (r_q.lcnt > q.plim);
          PC_TMO: ev = ~act & (s == r_q.s) & (r_q.cnt == q.plim);
          default: ev = 1'b0;
        endcase
      end
      TT_LOGIC: begin
        case (q.lcls)
          LC_PAT: ev = f & ~r_q.f;
          LC_STATE: ev = ck_e & f;
          // a data change on the clock edge itself sits inside the window
          LC_SH: ev = (ck_e & (r_q.dcnt < q.setup)) |
            ((r_d.d != r_q.d) & (ck_e | (r_q.hcnt < q.hold)));
          default: ev = 1'b0;
        endcase
      end
      default: ev = 1'b0;
    endcase
    r_d.ev = ev;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_q <= '{cnt: 16'h0, lcnt: 16'h0, dcnt: 16'hffff, hcnt: 16'hffff,
        default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign q.ev = r_q.ev;

  property p_edge;
    @(posedge ref_clk) disable iff (rst)
      (q.ttype == TT_EDGE && act && !pact) |=> q.ev;
  endproperty
  a_edge: assert property (p_edge) else $error("edge missed");

  property p_sh;
    @(posedge ref_clk) disable iff (rst)
      (q.ttype == TT_LOGIC && q.lcls == LC_SH && ck_e &&
       r_q.dcnt < q.setup) |=> q.ev;
  endproperty
  a_sh: assert property (p_sh) else $error("setup miss");
endmodule : atc_qual
`default_nettype wire

// ---- tb_acquisition_trigger_controller.sv ----
// testbench: self-checking bench for the acquisition trigger controller
`default_nettype none
module tb_acquisition_trigger_controller import atc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RL = 16;
  localparam int HM = 200;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] ch_hi = 4'h0;
  logic [3:0] ch_lo = 4'h0;
  logic line_hi = 1'b0;
  logic aux_hi = 1'b0;
  logic [2:0] cpl_sel;
  logic [2:0] trig_src;
  logic cap_we;
  logic [3:0] cap_addr;
  logic acq_done;
  logic st_arm;
  logic st_ready;
  logic st_trigd;
  int miscompares = 0;
  int num_checks = 0;
  int seed = 32'h72541242;
  int pre_n = 0;
  int post_n = 0;
  int done_n = 0;
  int hc = 0;
  int hc_seen = 0;
  logic [3:0] tz_e = 4'h0;
  logic arm_p = 1'b0;
  logic trg_p = 1'b0;

  atc_trig_ctrl #(.REC_LEN(RL), .HOLD_MAX(HM)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch_hi(ch_hi), .ch_lo(ch_lo),
    .line_hi(line_hi), .aux_hi(aux_hi), .cpl_sel(cpl_sel),
    .trig_src(trig_src), .cap_we(cap_we), .cap_addr(cap_addr),
    .acq_done(acq_done), .st_arm(st_arm), .st_ready(st_ready),
    .st_trigd(st_trigd));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // samples settled outputs away from the launching edge
  always @(negedge ref_clk) begin
    if (!rst) begin
      chk(32'($onehot0({st_arm, st_ready, st_trigd})), 32'h1);
      if (cap_we && arm_p) pre_n++;
      if (cap_we && trg_p) post_n++;
      // the sample stored on the accepting edge is time zero
      if (st_trigd && !trg_p) begin
        post_n = 0;
        tz_e = cap_addr;
      end
      if (st_arm && !arm_p) begin
        pre_n = 0;
        hc_seen = hc;
      end
      hc = acq_done ? 0 : hc + 1;
      done_n += int'(acq_done);
      arm_p = st_arm;
      trg_p = st_trigd;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  // all six source levels change together so no pin is driven twice
  task automatic drv(input logic [5:0] v, input logic [3:0] lo);
    @(posedge ref_clk);
    ch_hi <= v[3:0];
    line_hi <= v[4];
    aux_hi <= v[5];
    ch_lo <= lo;
  endtask : drv

  task automatic wait_done(input int d0, input int n, output bit got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(negedge ref_clk);
      got = done_n > d0;
    end
  endtask : wait_done

  task automatic wait_rdy();
    for (int i = 0; i < 300 && !st_ready; i++) @(negedge ref_clk);
    chk(32'(st_ready), 32'h1);
  endtask : wait_rdy

  task automatic stop();
    wr(A_CTRL, 32'h0);
    repeat (2) @(negedge ref_clk);
    chk(32'({st_arm, st_ready, st_trigd}), 32'h0);
  endtask : stop

  function automatic logic [31:0] mk(int s, logic sl, logic [1:0] t, int cl);
    mk = 32'h1 | (32'(sl) << B_SLOPE) | (32'(s) << B_SRC)
      | (32'(t) << B_TYPE) | (32'(cl) << ((t == TT_PULSE) ? B_PCLS : B_LCLS));
  endfunction : mk

  function automatic int pre_of(int pct);
    pre_of = ((pct > 100) ? 100 : pct) * RL / 100;
  endfunction : pre_of

  task automatic edge_rec(input int s, input logic sl, input int pct);
    logic [5:0] v;
    int c;
    int d0;
    bit got;
    v = 6'($random(seed));
    v[s] = sl;
    c = $unsigned($random(seed)) % 5;
    drv(v, 4'h0);
    repeat (6) @(posedge ref_clk);
    wr(A_PRE, 32'(pct));
    wr(A_CTRL, mk(s, sl, TT_EDGE, 0) | (32'(c) << B_CPL));
    repeat (2) @(negedge ref_clk);
    chk(32'(cpl_sel), 32'(c));
    chk(32'(trig_src), 32'(s));
    wait_rdy();
    d0 = done_n;
    v[s] = ~sl;
    drv(v, 4'h0);
    repeat (8) @(posedge ref_clk);
    v[s] = sl;
    drv(v, 4'h0);
    // long enough to pass the synchroniser, so it lands while locked out
    repeat (3) @(posedge ref_clk);
    v[s] = ~sl;
    drv(v, 4'h0);
    wait_done(d0, 60, got);
    chk(32'(got), 32'h1);
    chk(32'(pre_n), 32'(pre_of(pct)));
    chk(32'(post_n), 32'(RL - pre_of(pct)));
    chk(32'(done_n - d0), 32'h1);
    rd_chk(A_TZERO, 32'(tz_e));
    stop();
  endtask : edge_rec

  task automatic hold_rec(input int h, input logic dh, input int exp);
    int d0;
    bit got;
    logic [31:0] st;
    drv(6'h0, 4'h0);
    wr(A_TDIV, 32'h4);
    wr(A_HOLD, 32'(h));
    wr(A_CTRL, mk(0, 1'b0, TT_EDGE, 0) | (32'(dh) << B_DHOLD));
    wait_rdy();
    d0 = done_n;
    wait_done(d0, 40, got);
    chk(32'(got), 32'h0);
    wr(A_FORCE, 32'h0);
    wait_done(d0, 60, got);
    chk(32'(got), 32'h1);
    rd(A_STAT, st);
    chk(32'(st[5]), 32'h1);
    for (int i = 0; i < 300 && !st_arm; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    chk(32'(hc_seen), 32'(exp));
    wait_done(d0 + 1, 60, got);
    chk(32'(got), 32'h0);
    stop();
  endtask : hold_rec

  // pulse and logic rows: type, class, width, action, trigger expected
  localparam int NP = 11;
  int p_t [NP] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2};
  int p_c [NP] = '{0, 0, 2, 2, 1, 3, 4, 2, 0, 1, 1};
  int p_w [NP] = '{4, 24, 24, 4, 4, 24, 4, 0, 0, 0, 0};
  int p_a [NP] = '{1, 1, 1, 1, 2, 3, 1, 4, 5, 5, 4};
  int p_e [NP] = '{1, 0, 1, 0, 1, 1, 1, 1, 1, 1, 0};

  task automatic pulse_rec(input int r);
    int d0;
    bit got;
    drv(6'h0, 4'h0);
    repeat (6) @(posedge ref_clk);
    wr(A_CTRL, mk(1, 1'b0, 2'(p_t[r]), p_c[r]));
    repeat (2) @(negedge ref_clk);
    chk(32'(cpl_sel), 32'(CP_DC));
    wait_rdy();
    d0 = done_n;
    case (p_a[r])
      1: begin
        drv(6'h2, 4'h0);
        repeat (p_w[r]) @(posedge ref_clk);
        drv(6'h0, 4'h0);
      end
      2: begin
        drv(6'h0, 4'h2);
        repeat (p_w[r]) @(posedge ref_clk);
        drv(6'h0, 4'h0);
      end
      3: begin
        drv(6'h0, 4'h2);
        repeat (p_w[r]) @(posedge ref_clk);
        drv(6'h2, 4'h2);
      end
      5: drv(6'hf, 4'h0);
      default: drv(6'h9, 4'h0);
    endcase
    wait_done(d0, 60, got);
    chk(32'(got), 32'(p_e[r]));
    stop();
    repeat (HM + 20) @(posedge ref_clk);
  endtask : pulse_rec

  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    int d0;
    bit got;
    logic [31:0] st;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(A_CTRL, CTRL_RST);
    rd_chk(A_HOLD, HOLD_RST);
    rd_chk(A_TDIV, TDIV_RST);
    rd_chk(A_PRE, 32'(PRE_RST));
    rd_chk(A_PLIM, 32'(PLIM_RST));
    rd_chk(A_SHW, SHW_RST);
    wr(8'h24, 32'hffff_ffff);
    rd_chk(8'h24, 32'h0);
    rd_chk(A_FORCE, 32'h0);
    $display("test registers finished, miscompares %0d", miscompares);
    // a force while stopped must not survive into the next run
    wr(A_FORCE, 32'h0);
    rd_chk(A_STAT, 32'h0);
    wr(A_CTRL, mk(0, 1'b0, TT_EDGE, 0));
    wait_rdy();
    d0 = done_n;
    wait_done(d0, 60, got);
    chk(32'(got), 32'h0);
    stop();
    $display("test stopped force finished, miscompares %0d", miscompares);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 8; c++) begin
        wr(A_CTRL, (32'(t) << B_TYPE) | (32'(c) << B_CPL) | 32'h20);
        repeat (2) @(negedge ref_clk);
        chk(32'(cpl_sel), (t == 0 && c <= 4) ? 32'(c) : 32'h0);
      end
    end
    $display("test coupling finished, miscompares %0d", miscompares);
    edge_rec(0, 1'b0, 0);
    edge_rec(3, 1'b1, 120);
    for (int s = 0; s < 6; s++) begin
      edge_rec(s, 1'($random(seed)), $unsigned($random(seed)) % 100);
    end
    $display("test edge finished, miscompares %0d", miscompares);
    hold_rec(5, 1'b0, 13);
    hold_rec(1000, 1'b0, HM);
    hold_rec(13, 1'b1, 20);
    $display("test holdoff finished, miscompares %0d", miscompares);
    drv(6'h0, 4'h0);
    wr(A_TDIV, 32'h3);
    wr(A_CTRL, mk(0, 1'b0, TT_EDGE, 0) | (32'h1 << B_AUTO));
    d0 = done_n;
    wait_done(d0, 200, got);
    chk(32'(got), 32'h1);
    wait_done(d0 + 1, 200, got);
    chk(32'(got), 32'h1);
    rd(A_STAT, st);
    chk(32'(st[5]), 32'h1);
    stop();
    $display("test auto finished, miscompares %0d", miscompares);
    wr(A_HOLD, 32'h0);
    for (int r = 0; r < NP; r++) pulse_rec(r);
    $display("test qualifiers finished, miscompares %0d", miscompares);
    tally_and_finish();
  end
endmodule : tb_acquisition_trigger_controller
`default_nettype wire
